/* core/safety_output_map.svh */
// register map, field positions, reset values and timing figures
// assumes a 125 MHz system clock and 32-bit APB words
`ifndef SAFETY_OUTPUT_MAP_SVH
`define SAFETY_OUTPUT_MAP_SVH

// byte addresses
`define SOC_ADDR_CTRL 8'h00
`define SOC_ADDR_STATUS 8'h04
`define SOC_ADDR_DELAY 8'h08
`define SOC_ADDR_NAME0 8'h10
`define SOC_ADDR_NAME_LAST 8'h24

// control fields
`define SOC_CTRL_RII_BIT 0
`define SOC_CTRL_FBM_BIT 1
`define SOC_CTRL_ESTOP_BIT 2
`define SOC_CTRL_MODE_LSB 4
`define SOC_CTRL_START_BIT 8

// reset values and the delay minimum
`define SOC_CTRL_RST 3'h1
`define SOC_MODE_RST 2'h1
`define SOC_DELAY_RST 5'h01
`define SOC_DELAY_MIN 5'h01

// application name storage
`define SOC_NAME_CHARS 22
`define SOC_NAME_WORDS 6
`define SOC_NAME_LAST_MASK 32'h0000FFFF

// timing
`define SOC_CLK_KHZ 125000
`define SOC_ESTOP_RESP_MS 200
`define SOC_FB_TIME_MS 100
`define SOC_DELAY_STEP_MS 100

// display codes
`define SOC_CODE_NONE 8'h00
`define SOC_CODE_ESTOP 8'h11
`define SOC_CODE_FEEDBACK 8'h31
`define SOC_CODE_LOCKOUT 8'h32
`define SOC_CODE_ESTOP_CFG 8'h33

`endif

/* core/safety_output_pkg.sv */
// types shared by the safety output interlock controller
// assumes the map header supplies every number
`default_nettype none

package safety_output_pkg;

    typedef enum logic [1:0] {
        SIG_CONTAMINATION,
        SIG_OUTPUT_STATUS,
        SIG_ESTOP_STATUS,
        SIG_UNUSED
    } sig_mode_t;

    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_WAIT_RESET,
        ST_FB_ERROR,
        ST_ON,
        ST_LOCKOUT
    } fsm_t;

    typedef struct packed {
        sig_mode_t mode;
        logic estop_en;
        logic fbm_en;
        logic rii_en;
    } ctrl_t;

    typedef struct packed {
        fsm_t fsm;
        ctrl_t ctrl;
        logic [4:0] delay;
        logic [5:0][31:0] name;
        logic btn_prev;
        logic [31:0] fb_cnt;
        logic [31:0] sig_cnt;
        logic [7:0] lock_code;
        logic on;
        logic rr;
        logic green;
        logic red;
        logic sig;
        logic [7:0] code;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

endpackage : safety_output_pkg

`default_nettype wire

/* core/safety_output_interlock_control.sv */
// safety output controller: restart interlock, contactor feedback check,
// two-channel emergency stop and the configurable signal output
// assumes all pins synchronous to CLK_SYS, APB4 slave for configuration
//
// The implementer's own choices: register access over APB and the register offsets.
`include "safety_output_map.svh"
`default_nettype none

// Contract
// - configuration keeps an application name of at most 22 characters.
// - with restart interlock, path break turns outputs off until reset press.
// - valid reset press while waiting turns outputs on, red to green.
// - reset-required output is high while interlock waits for reset.
// - contactor feedback checked after each break and before restart.
// - failed feedback check shows error code, outputs stay off, red.
// - unreachable safe state latches lock-out with lock-out code.
// - emergency stop turns outputs off, red, shows emergency stop code.
// - emergency stop overrides an active bypass.
// - emergency stop switches outputs off within 200 ms.
// - power-up compares stop setting with connected contact; mismatch locks.
// - signal output takes exactly one configured source.
// - status mode follows red at once, green after 0.1 to 3.1 s.
// - stop status mode asserts signal while stop is actuated.
// - contamination mode asserts signal on contaminated front screen.
// - green while outputs on, red while outputs off.
module safety_output_interlock_control #(
    parameter int unsigned FB_TIME_CYCLES =
        `SOC_FB_TIME_MS * `SOC_CLK_KHZ,
    parameter int unsigned DELAY_STEP_CYCLES =
        `SOC_DELAY_STEP_MS * `SOC_CLK_KHZ
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LIGHT_PATH_CLEAR,
    input wire logic BYPASS_ACTIVE,
    input wire logic RESET_BUTTON,
    input wire logic FEEDBACK_CLOSED,
    input wire logic [1:0] ESTOP_CH_CLOSED,
    input wire logic ESTOP_CONNECTED,
    input wire logic CONTAMINATED,
    output logic SAFETY_SWITCHING_OUTPUTS,
    output logic RESET_REQUIRED,
    output logic IND_GREEN,
    output logic IND_RED,
    output logic CONFIGURABLE_SIGNAL_OUTPUT,
    output logic [7:0] DISPLAY_CODE
);

    // stop reaction is one cycle, far inside the allowed response time
    // figure kept for any slower stop filter to be held against
    localparam int unsigned ESTOP_RESP_CYCLES =
        `SOC_ESTOP_RESP_MS * `SOC_CLK_KHZ;

    safety_output_pkg::state_t s_reg;
    safety_output_pkg::state_t s_next;

    // byte-lane merge for register writes
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // word index into the name storage, valid only when in range
    function automatic logic [2:0] name_index(input logic [7:0] addr);
        logic [7:0] off;
        off = addr - `SOC_ADDR_NAME0;
        return off[4:2];
    endfunction : name_index

    // aligned address inside the name window
    function automatic logic is_name(input logic [7:0] addr);
        return addr[1:0] == 2'h0 && addr >= `SOC_ADDR_NAME0 &&
            addr <= `SOC_ADDR_NAME_LAST;
    endfunction : is_name

    // one-hot select shared by read and write paths:
    // bit 0 control, 1 status, 2 delay, 3 name words
    function automatic logic [3:0] reg_sel(input logic [7:0] addr);
        logic [3:0] hit;
        hit[0] = addr == `SOC_ADDR_CTRL;
        hit[1] = addr == `SOC_ADDR_STATUS;
        hit[2] = addr == `SOC_ADDR_DELAY;
        hit[3] = is_name(addr);
        return hit;
    endfunction : reg_sel

    logic estop_act;
    logic light_ok;
    logic btn_edge;
    logic fb_timeout;
    logic start_pulse;
    logic bus_access;
    logic bus_commit;
    logic [31:0] sig_target;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [3:0] sel;
    logic cfg_estop;

    // stop sensing; bypass only masks the light path, never the stop
    always_comb begin
        estop_act = s_reg.ctrl.estop_en && !(&ESTOP_CH_CLOSED);
        light_ok = LIGHT_PATH_CLEAR || BYPASS_ACTIVE;
        btn_edge = RESET_BUTTON && !s_reg.btn_prev;
        fb_timeout = s_reg.fb_cnt >= FB_TIME_CYCLES;
        sig_target = 32'(s_reg.delay) * DELAY_STEP_CYCLES;
        bus_access = PSEL && PENABLE;
        bus_commit = bus_access && s_reg.pready && PWRITE;
        sel = reg_sel(PADDR);
        start_pulse = bus_commit && sel[0] &&
            PSTRB[1] && PWDATA[`SOC_CTRL_START_BIT];
        // config and start may share one write, so the power-up check
        // must see the stop bit being written, not the stored one
        cfg_estop = PSTRB[0] ? PWDATA[`SOC_CTRL_ESTOP_BIT] :
            s_reg.ctrl.estop_en;
    end

    // register read views
    always_comb begin
        ctrl_word = 32'h0;
        ctrl_word[`SOC_CTRL_RII_BIT] = s_reg.ctrl.rii_en;
        ctrl_word[`SOC_CTRL_FBM_BIT] = s_reg.ctrl.fbm_en;
        ctrl_word[`SOC_CTRL_ESTOP_BIT] = s_reg.ctrl.estop_en;
        ctrl_word[`SOC_CTRL_MODE_LSB +: 2] = s_reg.ctrl.mode;
        status_word = {13'h0, s_reg.fsm, s_reg.code, 3'h0,
            estop_act, s_reg.fsm == safety_output_pkg::ST_LOCKOUT,
            s_reg.rr, s_reg.sig, s_reg.on};
    end

    // one next-state process for the whole block
    always_comb begin
        logic [31:0] wv;
        wv = 32'h0;
        s_next = s_reg;
        s_next.btn_prev = RESET_BUTTON;

        // contactors must drop within the feedback window once off
        // counter saturates, so a long wait never wraps back to zero
        if (s_reg.on || !s_reg.ctrl.fbm_en || FEEDBACK_CLOSED) begin
            s_next.fb_cnt = 32'h0;
        end else if (!fb_timeout) begin
            s_next.fb_cnt = s_reg.fb_cnt + 32'h1;
        end

        case (s_reg.fsm)
            safety_output_pkg::ST_POWERUP: begin
                // outputs stay off until software starts the block
                s_next.on = 1'b0;
                if (start_pulse) begin
                    if (cfg_estop != ESTOP_CONNECTED) begin
                        s_next.fsm = safety_output_pkg::ST_LOCKOUT;
                        s_next.lock_code = `SOC_CODE_ESTOP_CFG;
                    end else begin
                        s_next.fsm = safety_output_pkg::ST_WAIT_RESET;
                    end
                end
            end
            safety_output_pkg::ST_WAIT_RESET: begin
                // a timeout here means the contactors never dropped
                s_next.on = 1'b0;
                if (fb_timeout) begin
                    s_next.fsm = safety_output_pkg::ST_LOCKOUT;
                    s_next.lock_code = `SOC_CODE_LOCKOUT;
                end else if (!estop_act && light_ok &&
                    (!s_reg.ctrl.rii_en || btn_edge)) begin
                    if (s_reg.ctrl.fbm_en && !FEEDBACK_CLOSED) begin
                        s_next.fsm = safety_output_pkg::ST_FB_ERROR;
                    end else begin
                        s_next.fsm = safety_output_pkg::ST_ON;
                        s_next.on = 1'b1;
                    end
                end
            end
            safety_output_pkg::ST_FB_ERROR: begin
                // no restart until feedback closes; a fused contact times out
                s_next.on = 1'b0;
                if (fb_timeout) begin
                    s_next.fsm = safety_output_pkg::ST_LOCKOUT;
                    s_next.lock_code = `SOC_CODE_LOCKOUT;
                end else if (FEEDBACK_CLOSED) begin
                    s_next.fsm = safety_output_pkg::ST_WAIT_RESET;
                end
            end
            safety_output_pkg::ST_ON: begin
                // stop and broken path both fall back to waiting
                if (estop_act || !light_ok) begin
                    s_next.fsm = safety_output_pkg::ST_WAIT_RESET;
                    s_next.on = 1'b0;
                end
            end
            safety_output_pkg::ST_LOCKOUT: begin
                // latched until the next reset
                s_next.on = 1'b0;
            end
            default: begin
                // an illegal state is a fault, never a reason to run
                s_next.fsm = safety_output_pkg::ST_LOCKOUT;
                s_next.lock_code = `SOC_CODE_LOCKOUT;
                s_next.on = 1'b0;
            end
        endcase

        // indication follows the next output state
        s_next.green = s_next.on;
        s_next.red = !s_next.on;
        s_next.rr = s_reg.ctrl.rii_en &&
            s_next.fsm == safety_output_pkg::ST_WAIT_RESET;

        // display code, lock-out wins over everything
        if (s_next.fsm == safety_output_pkg::ST_LOCKOUT) begin
            s_next.code = s_next.lock_code;
        end else if (estop_act) begin
            s_next.code = `SOC_CODE_ESTOP;
        end else if (s_next.fsm == safety_output_pkg::ST_FB_ERROR) begin
            s_next.code = `SOC_CODE_FEEDBACK;
        end else begin
            s_next.code = `SOC_CODE_NONE;
        end

        // green side of the status signal is delayed, red side is not
        if (!s_next.on) begin
            s_next.sig_cnt = 32'h0;
        end else if (s_reg.sig_cnt < sig_target) begin
            s_next.sig_cnt = s_reg.sig_cnt + 32'h1;
        end

        // the spare mode code keeps the output low
        case (s_reg.ctrl.mode)
            safety_output_pkg::SIG_CONTAMINATION: begin
                s_next.sig = CONTAMINATED;
            end
            safety_output_pkg::SIG_OUTPUT_STATUS: begin
                s_next.sig = s_next.on &&
                    s_reg.sig_cnt >= sig_target;
            end
            safety_output_pkg::SIG_ESTOP_STATUS: begin
                s_next.sig = estop_act;
            end
            default: begin
                s_next.sig = 1'b0;
            end
        endcase

        // apb: one wait state, read data and error prepared beforehand
        // error leaves with ready, so the master sees both in one cycle
        if (bus_access && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.pslverr = 1'b0;
            s_next.prdata = 32'h0;
            if (sel[0]) begin
                s_next.prdata = ctrl_word;
            end else if (sel[1]) begin
                s_next.prdata = status_word;
            end else if (sel[2]) begin
                s_next.prdata = {27'h0, s_reg.delay};
            end else if (sel[3]) begin
                s_next.prdata = s_reg.name[name_index(PADDR)];
            end else begin
                s_next.pslverr = 1'b1;
            end
        end else begin
            s_next.pready = 1'b0;
            s_next.pslverr = 1'b0;
        end

        // writes take effect on the edge that completes the access
        if (bus_commit) begin
            if (sel[0]) begin
                wv = merge_bytes(ctrl_word, PWDATA, PSTRB);
                s_next.ctrl.rii_en = wv[`SOC_CTRL_RII_BIT];
                s_next.ctrl.fbm_en = wv[`SOC_CTRL_FBM_BIT];
                s_next.ctrl.estop_en = wv[`SOC_CTRL_ESTOP_BIT];
                s_next.ctrl.mode = safety_output_pkg::sig_mode_t'(
                    wv[`SOC_CTRL_MODE_LSB +: 2]);
            end else if (sel[1]) begin
                // status is read-only; a write is dropped without error
                wv = 32'h0;
            end else if (sel[2]) begin
                wv = merge_bytes({27'h0, s_reg.delay}, PWDATA, PSTRB);
                // zero would mean no delay; clamp to the shortest step
                s_next.delay = wv[4:0] == 5'h0 ?
                    `SOC_DELAY_MIN : wv[4:0];
            end else if (sel[3]) begin
                wv = merge_bytes(s_reg.name[name_index(PADDR)],
                    PWDATA, PSTRB);
                // last word holds only the final two characters
                if (PADDR == `SOC_ADDR_NAME_LAST) begin
                    wv = wv & `SOC_NAME_LAST_MASK;
                end
                s_next.name[name_index(PADDR)] = wv;
            end
        end
    end

    // single state register; reset leaves outputs off and red, and the
    // lock code is preset so an illegal state still shows lock-out
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            s_reg <= '0;
            s_reg.fsm <= safety_output_pkg::ST_POWERUP;
            s_reg.ctrl.rii_en <= 1'(`SOC_CTRL_RST);
            s_reg.ctrl.mode <= safety_output_pkg::sig_mode_t'(
                `SOC_MODE_RST);
            s_reg.delay <= `SOC_DELAY_RST;
            s_reg.red <= 1'b1;
            s_reg.lock_code <= `SOC_CODE_LOCKOUT;
        end else begin
            s_reg <= s_next;
        end
    end

    // every output straight from the state register
    assign PRDATA = s_reg.prdata;
    assign PREADY = s_reg.pready;
    assign PSLVERR = s_reg.pslverr;
    assign SAFETY_SWITCHING_OUTPUTS = s_reg.on;
    assign RESET_REQUIRED = s_reg.rr;
    assign IND_GREEN = s_reg.green;
    assign IND_RED = s_reg.red;
    assign CONFIGURABLE_SIGNAL_OUTPUT = s_reg.sig;
    assign DISPLAY_CODE = s_reg.code;

endmodule : safety_output_interlock_control

`default_nettype wire

/* verification/soc_props.sv */
// port checker for the safety output interlock controller
// assumes it is bound onto the controller, one clock domain
`include "safety_output_map.svh"
`default_nettype none

module soc_props #(
    parameter int unsigned FB_TIME_CYCLES = 20,
    parameter int unsigned DELAY_STEP_CYCLES = 4
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic LIGHT_PATH_CLEAR,
    input wire logic BYPASS_ACTIVE,
    input wire logic RESET_BUTTON,
    input wire logic [1:0] ESTOP_CH_CLOSED,
    input wire logic SAFETY_SWITCHING_OUTPUTS,
    input wire logic RESET_REQUIRED,
    input wire logic IND_GREEN,
    input wire logic IND_RED,
    input wire logic [7:0] DISPLAY_CODE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // short aliases keep the properties readable
    wire logic on = SAFETY_SWITCHING_OUTPUTS;
    wire logic [7:0] code = DISPLAY_CODE;
    wire logic stop = !(&ESTOP_CH_CLOSED);

    AST_STOP_OFF: assert property (stop |=> !on)
        else $error("outputs stayed on under stop");
    AST_STOP_CODE: assert property (on && stop |=>
        code == `SOC_CODE_ESTOP) else $error("stop code missing");
    AST_PATH_OFF: assert property
        (!LIGHT_PATH_CLEAR && !BYPASS_ACTIVE |=> !on)
        else $error("outputs stayed on with path broken");
    AST_HOLD_OFF: assert property
        (RESET_REQUIRED && !on && !RESET_BUTTON |=> !on)
        else $error("restart without a press");
    AST_PRESS: assert property ($rose(on) && $past(RESET_REQUIRED)
        |-> $past(RESET_BUTTON) && !$past(RESET_BUTTON, 2))
        else $error("restart not tied to a press edge");
    AST_RR_OFF: assert property (RESET_REQUIRED |-> !on)
        else $error("reset required while outputs on");
    AST_LAMPS: assert property (IND_GREEN == on && IND_RED != on)
        else $error("indicator disagrees with outputs");
    AST_FB_ERR: assert property (code == `SOC_CODE_FEEDBACK
        |-> !on && IND_RED) else $error("feedback error with outputs on");
    AST_LOCK: assert property (code == `SOC_CODE_LOCKOUT |=>
        code == `SOC_CODE_LOCKOUT && !on) else $error("lock-out left");
    AST_CFG_LOCK: assert property (code == `SOC_CODE_ESTOP_CFG |=>
        code == `SOC_CODE_ESTOP_CFG && !on) else $error("cfg lock left");

    // main scenarios reached
    cover property ($rose(on));
    cover property (on && stop);
    cover property (code == `SOC_CODE_LOCKOUT);
endmodule : soc_props

bind safety_output_interlock_control soc_props #(
    .FB_TIME_CYCLES(FB_TIME_CYCLES),
    .DELAY_STEP_CYCLES(DELAY_STEP_CYCLES)
) props (
    .CLK_SYS(CLK_SYS),
    .SRST(SRST),
    .LIGHT_PATH_CLEAR(LIGHT_PATH_CLEAR),
    .BYPASS_ACTIVE(BYPASS_ACTIVE),
    .RESET_BUTTON(RESET_BUTTON),
    .ESTOP_CH_CLOSED(ESTOP_CH_CLOSED),
    .SAFETY_SWITCHING_OUTPUTS(SAFETY_SWITCHING_OUTPUTS),
    .RESET_REQUIRED(RESET_REQUIRED),
    .IND_GREEN(IND_GREEN),
    .IND_RED(IND_RED),
    .DISPLAY_CODE(DISPLAY_CODE)
);

`default_nettype wire

/* verification/machine_model.sv */
// contactors and machine restart logic beyond the safety outputs
// assumes the bench commands the fused and slow contact faults
`default_nettype none

module machine_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic energise,
    input wire logic fused,
    input wire logic slow,
    input wire logic device_btn,
    input wire logic restart_btn,
    output logic feedback_closed,
    output logic run
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] drop_reg;
    logic armed_reg;

    // contacts drop some cycles after the coil; a fused one never does
    always_ff @(posedge clk) begin
        if (srst || energise) drop_reg <= 3'h0;
        else if (drop_reg != 3'h7) drop_reg <= drop_reg + 3'h1;
    end
    assign feedback_closed = !fused &&
        (slow ? drop_reg == 3'h7 : drop_reg != 3'h0);

    // own interlock: device reset first, then the machine button
    always_ff @(posedge clk) begin
        if (srst) armed_reg <= 1'b0;
        else if (device_btn) armed_reg <= 1'b1;
        else if (run) armed_reg <= 1'b0;
        if (srst || !energise) run <= 1'b0;
        else if (restart_btn && armed_reg) run <= 1'b1;
    end
endmodule : machine_model

`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the safety output interlock controller
// assumes the machine model closes the contactor feedback loop
`include "safety_output_map.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FB = 20;
    localparam int STEP = 4;
    logic clk, srst, psel, pen, pwr, pready, pslverr, err;
    logic [7:0] paddr, code;
    logic [31:0] pwdata, prdata, rd;
    logic light, byp, btn, fbk, econ, cont, on, rr, grn, red, sig;
    logic fused, slow, mbtn, run;
    logic [1:0] ech;
    int bad_count, checks, n;

    safety_output_interlock_control #(.FB_TIME_CYCLES(FB),
        .DELAY_STEP_CYCLES(STEP)) dut (
        .CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LIGHT_PATH_CLEAR(light), .BYPASS_ACTIVE(byp),
        .RESET_BUTTON(btn), .FEEDBACK_CLOSED(fbk),
        .ESTOP_CH_CLOSED(ech), .ESTOP_CONNECTED(econ),
        .CONTAMINATED(cont), .SAFETY_SWITCHING_OUTPUTS(on),
        .RESET_REQUIRED(rr), .IND_GREEN(grn), .IND_RED(red),
        .CONFIGURABLE_SIGNAL_OUTPUT(sig), .DISPLAY_CODE(code));
    machine_model partner (.clk(clk), .srst(srst), .energise(on),
        .fused(fused), .slow(slow), .device_btn(btn),
        .restart_btn(mbtn), .feedback_closed(fbk), .run(run));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic wrap_up;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick

    // request held until pready is sampled; idle cycle after each
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            bad_count++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic press;
        btn <= 1'b1;
        tick(2);
        btn <= 1'b0;
    endtask : press

    task automatic boot(input logic [31:0] ctl);
        srst <= 1'b1;
        tick(3);
        srst <= 1'b0;
        tick(1);
        apb(1'b1, `SOC_ADDR_CTRL, ctl);
        tick(3);
    endtask : boot

    initial begin
        {psel, pen, pwr, paddr, pwdata, btn, byp, cont} = '0;
        {fused, slow, mbtn} = '0;
        {srst, light, econ, ech} = '1;
        tick(3);
        srst <= 1'b0;
        tick(1);
        apb(1'b0, `SOC_ADDR_CTRL, 32'h0);
        chk(rd, 32'h11);
        apb(1'b1, `SOC_ADDR_DELAY, 32'h0);
        apb(1'b0, `SOC_ADDR_DELAY, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `SOC_ADDR_NAME_LAST, 32'hFFFFFFFF);
        apb(1'b0, `SOC_ADDR_NAME_LAST, 32'h0);
        chk(rd, 32'h0000FFFF);
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[31:1], err}, 32'h1);
        apb(1'b1, `SOC_ADDR_DELAY, 32'h2);
        $display("test registers done");
        // interlock, feedback monitor, stop, status-delay mode, start
        apb(1'b1, `SOC_ADDR_CTRL, 32'h117);
        tick(3);
        chk({31'h0, rr}, 32'h1);
        mbtn <= 1'b1;
        tick(2);
        chk({31'h0, run}, 32'h0);
        press();
        chk({29'h0, on, grn, red}, 32'h6);
        for (n = 0; sig !== 1'b1 && n < 40; n++) tick(1);
        chk(n, 2 * STEP);
        chk({31'h0, run}, 32'h1);
        mbtn <= 1'b0;
        light <= 1'b0;
        tick(2);
        chk({29'h0, on, sig, rr}, 32'h1);
        light <= 1'b1;
        tick(5);
        chk({31'h0, on}, 32'h0);
        press();
        chk({31'h0, on}, 32'h1);
        $display("test restart done");
        slow <= 1'b1;
        light <= 1'b0;
        tick(2);
        light <= 1'b1;
        tick(1);
        press();
        chk({22'h0, code, on, red}, {22'h0, `SOC_CODE_FEEDBACK, 2'h1});
        tick(15);
        press();
        chk({31'h0, on}, 32'h1);
        fused <= 1'b1;
        light <= 1'b0;
        tick(FB + 5);
        light <= 1'b1;
        press();
        chk({23'h0, code, on}, {23'h0, `SOC_CODE_LOCKOUT, 1'b0});
        $display("test feedback done");
        fused <= 1'b0;
        slow <= 1'b0;
        boot(32'h127);
        press();
        byp <= 1'b1;
        light <= 1'b0;
        tick(2);
        chk({31'h0, on}, 32'h1);
        ech <= 2'b10;
        tick(2);
        chk({22'h0, code, on, sig},
            {22'h0, `SOC_CODE_ESTOP, 2'h1});
        {ech, byp, light} <= 4'hD;
        tick(3);
        press();
        ech <= 2'b01;
        tick(2);
        chk({30'h0, on, red}, 32'h1);
        ech <= 2'b11;
        apb(1'b1, `SOC_ADDR_CTRL, 32'h07);
        cont <= 1'b1;
        tick(2);
        chk({31'h0, sig}, 32'h1);
        apb(1'b1, `SOC_ADDR_CTRL, 32'h37);
        tick(2);
        chk({31'h0, sig}, 32'h0);
        cont <= 1'b0;
        $display("test stop and signal done");
        econ <= 1'b0;
        boot(32'h105);
        chk({24'h0, code}, {24'h0, `SOC_CODE_ESTOP_CFG});
        apb(1'b0, `SOC_ADDR_STATUS, 32'h0);
        chk(rd, 32'h00043308);
        $display("test power-up check done");
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
